// File: core/can_fifo_dev.sv
// Purpose: Channel message FIFO in receive mode with its registers and transmit buffers.
// Assumes: Link requests come from can_fifo_ctrl; tx events come from the protocol core.
// Notes:   Clearing the enable empties the FIFO but keeps pending flags.
// Behaviour
// - One combined FIFO per channel, rx or tx
// - Count stored messages in six bits
// - Full when count equals configured nonzero depth
// - Empty once all messages are released
// - Read registers show oldest unreleased message
// - Standard identifier in low eleven bits only
// - Replace length from rule when both enabled
// - Store matching rule label with message
// - Unfilled data bytes read as zero
// - Writing FF to pointer control releases message
// - Software advances only when enabled, not empty
// - Threshold mode raises request at fill level
// - Per-message mode raises request every store
// - Disabling keeps pending receive request flag
// - Receive request gated by own enable
// - Software avoids zero thresholds at depth four
// - Message loss raises global error when enabled
// - Four transmit buffers, optionally linked
// - Software zeroes control of linked buffers
// - Linked buffers leave status flags untouched
// - Buffers send data or remote frames
`timescale 1ns/10ps
`default_nettype none
module can_fifo_dev #(
	parameter int MAX_DEPTH = 48
) (
	input  wire logic                                 clk_i,
	input  wire logic                                 rst_i,
	can_fifo_if.device                                link,
	input  wire logic                                 tx_done_i,
	input  wire logic [can_fifo_pkg::TXB_IDX_W-1:0]   tx_buf_i,
	input  wire logic                                 tx_aborted_i,
	output logic      [can_fifo_pkg::NUM_TXB-1:0]     tx_req_o,
	output logic      [can_fifo_pkg::NUM_TXB-1:0]     tx_remote_o,
	output logic                                      rx_irq_o,
	output logic                                      err_irq_o,
	output logic                                      tx_irq_o
);
	import can_fifo_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [31:0]          cfg, next_cfg;
	logic [1:0]           gcfg, next_gcfg;
	logic                 msg_lost_irq_enable, next_msg_lost_irq_enable;
	logic [CNT_W-1:0]     count, next_count;
	logic [CNT_W-1:0]     wr_ptr, next_wr_ptr;
	logic [CNT_W-1:0]     rd_ptr, next_rd_ptr;
	logic                 empty, next_empty;
	logic                 full, next_full;
	logic                 lost, next_lost;
	logic                 rxif, next_rxif;
	logic                 ack, next_ack;
	logic [31:0]          rdata, next_rdata;
	logic                 rx_irq, next_rx_irq;
	logic                 err_irq, next_err_irq;
	logic                 tx_irq, next_tx_irq;
	logic [NUM_TXB-1:0]   pend, next_pend;
	logic [NUM_TXB-1:0]   rem, next_rem;
	logic [NUM_TXB-1:0]   tie, next_tie;
	logic [NUM_TXB-1:0]   linkm, next_linkm;
	logic [NUM_TXB-1:0]   cmpl, next_cmpl;
	logic [NUM_TXB-1:0]   abrt, next_abrt;
	logic [2*NUM_TXB-1:0] res, next_res;
	logic [NUM_TXB-1:0]   tx_req, next_tx_req;

	logic                 fifo_en;
	logic                 tx_mode;
	logic [CNT_W-1:0]     depth;
	logic                 wr;
	logic                 store;
	logic                 lose;
	logic                 room;
	logic                 adv;
	logic [NUM_TXB-1:0]   linked;
	msg_t                 in_msg;
	msg_t                 head;
	logic [DLC_W-1:0]     st_dlc;

	function automatic logic [CNT_W-1:0] ptr_step(input logic [CNT_W-1:0] p,
			input logic [CNT_W-1:0] d);
		return (p == d - 6'h01) ? 6'h00 : p + 6'h01;
	endfunction : ptr_step

	function automatic logic [DATA_W-1:0] mask_data(input logic [DATA_W-1:0] d,
			input logic [DLC_W-1:0] n);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < 8; i++) begin
			if (4'(i) < n) begin
				m[8*i +: 8] = d[8*i +: 8];
			end
		end
		return m;
	endfunction : mask_data

	////////////////////////////////////////////////////////////////////////////////
	// Receive path into storage
	assign fifo_en = cfg[CFG_EN];
	assign tx_mode = cfg[CFG_TXMODE];
	assign depth   = depth_of(cfg[CFG_DEPTH +: 3]);
	assign wr      = link.reg_req && link.reg_we;
	// Depth code zero holds nothing, so every offered message is lost
	assign room    = !full && (depth != 6'h00);
	assign store   = link.rx_valid && fifo_en && !tx_mode && room;
	assign lose    = link.rx_valid && fifo_en && !tx_mode && !room;
	assign adv     = wr && link.reg_addr == REG_PTRCTL && link.reg_wdata[7:0] == PTR_ADVANCE
		&& fifo_en && !empty;
	assign linked  = linkm & {NUM_TXB{tx_mode}};
	assign st_dlc  = (gcfg[GCFG_DCE] && gcfg[GCFG_DRE]) ? link.rule_dlc : link.rx_dlc;

	assign in_msg = '{
		ide:   link.rx_ide,
		id:    link.rx_ide ? link.rx_id : {18'h00000, link.rx_id[STD_ID_W-1:0]},
		stamp: link.rx_stamp,
		label: link.rule_label,
		dlc:   st_dlc,
		data:  mask_data(link.rx_data, st_dlc)
	};

	msg_store #(
		.WIDTH ($bits(msg_t)),
		.DEPTH (MAX_DEPTH),
		.AW    (CNT_W)
	) u_store (
		.clk_i     (clk_i),
		.wr_en_i   (store),
		.wr_addr_i (wr_ptr),
		.wr_data_i (in_msg),
		.rd_addr_i (rd_ptr),
		.rd_data_o (head)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		next_cfg     = cfg;
		next_gcfg    = gcfg;
		next_msg_lost_irq_enable    = msg_lost_irq_enable;
		next_count   = count;
		next_wr_ptr  = wr_ptr;
		next_rd_ptr  = rd_ptr;
		next_lost    = lost;
		next_rxif    = rxif;
		next_ack     = link.reg_req;
		next_rdata   = rdata;
		next_pend    = pend;
		next_rem     = rem;
		next_tie     = tie;
		next_linkm   = linkm;
		next_cmpl    = cmpl;
		next_abrt    = abrt;
		next_res     = res;
		if (store) begin
			next_wr_ptr = ptr_step(wr_ptr, depth);
		end
		if (adv) begin
			next_rd_ptr = ptr_step(rd_ptr, depth);
		end
		next_count = count + 6'(store) - 6'(adv);
		if (wr) begin
			unique case (link.reg_addr)
				REG_CONFIG: next_cfg = link.reg_wdata;
				REG_STATUS: begin
					if (link.reg_wdata[STS_LOST]) next_lost = 1'b0;
					if (link.reg_wdata[STS_RXIF]) next_rxif = 1'b0;
				end
				REG_GCFG:   next_gcfg = link.reg_wdata[1:0];
				REG_GLOBAL_CONTROL_REG:  next_msg_lost_irq_enable = link.reg_wdata[GLOBAL_CONTROL_REG_MSG_LOST_IRQ_ENABLE];
				REG_TXCTL: begin
					for (int b = 0; b < NUM_TXB; b++) begin
						if (!linked[b]) begin
							next_pend[b] = pend[b] | link.reg_wdata[8*b];
							next_rem[b]  = link.reg_wdata[8*b+1];
						end
					end
				end
				REG_TXIE: begin
					next_tie   = link.reg_wdata[NUM_TXB-1:0];
					next_linkm = link.reg_wdata[TX_LINK +: NUM_TXB];
				end
				REG_TXSTAT: begin
					for (int b = 0; b < NUM_TXB; b++) begin
						if (link.reg_wdata[TX_CMPL+b] || link.reg_wdata[TX_ABRT+b]) begin
							next_cmpl[b]      = cmpl[b] & ~link.reg_wdata[TX_CMPL+b];
							next_abrt[b]      = abrt[b] & ~link.reg_wdata[TX_ABRT+b];
							next_res[2*b +: 2] = 2'h0;
						end
					end
				end
				default: ;
			endcase
		end
		// Flag sets follow clears so a same-cycle event wins
		if (lose) begin
			next_lost = 1'b1;
		end
		if (store && (cfg[CFG_IRQM] || next_count == threshold_of(depth, cfg[CFG_THR +: 3]))) begin
			next_rxif = 1'b1;
		end
		if (tx_done_i && !linked[tx_buf_i]) begin
			next_pend[tx_buf_i] = 1'b0;
			next_cmpl[tx_buf_i] = next_cmpl[tx_buf_i] | ~tx_aborted_i;
			next_abrt[tx_buf_i] = next_abrt[tx_buf_i] | tx_aborted_i;
			next_res[2*tx_buf_i +: 2] = tx_aborted_i ? RES_ABORT : RES_DONE;
		end
		if (!fifo_en) begin
			next_count  = 6'h00;
			next_wr_ptr = 6'h00;
			next_rd_ptr = 6'h00;
		end
		next_full  = (next_count == depth) && (depth != 6'h00);
		next_empty = (next_count == 6'h00);
		next_rx_irq  = rxif && cfg[CFG_RXIE];
		next_err_irq = lost && msg_lost_irq_enable;
		next_tx_irq  = |(cmpl & tie & ~linked);
		next_tx_req  = next_pend & ~(next_linkm & {NUM_TXB{next_cfg[CFG_TXMODE]}});
		if (link.reg_req && !link.reg_we) begin
			next_rdata = 32'h0000_0000;
			unique case (link.reg_addr)
				REG_CONFIG:  next_rdata = cfg;
				REG_STATUS:  next_rdata = {18'h00000, count, 4'h0, rxif, lost, full, empty};
				REG_ID_LOW:  next_rdata = {16'h0000, head.id[15:0]};
				REG_ID_HIGH: next_rdata = {16'h0000, head.ide, 2'h0, head.id[ID_W-1:16]};
				REG_STAMP:   next_rdata = {16'h0000, head.stamp};
				REG_LBL_DLC: next_rdata = {head.label, 4'h0, head.dlc, 12'h000};
				REG_DATA0:   next_rdata = head.data[31:0];
				REG_DATA1:   next_rdata = head.data[63:32];
				REG_GCFG:    next_rdata = {30'h00000000, gcfg};
				REG_GLOBAL_CONTROL_REG:   next_rdata = {31'h00000000, msg_lost_irq_enable};
				REG_TXCTL: begin
					for (int b = 0; b < NUM_TXB; b++) begin
						next_rdata[8*b +: 2] = {rem[b], pend[b]};
					end
				end
				REG_TXIE:    next_rdata = {20'h00000, linkm, 4'h0, tie};
				REG_TXSTAT:  next_rdata = {res, 4'h0, abrt, 4'h0, cmpl, 4'h0, pend};
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg     <= CONFIG_RST;
			gcfg    <= 2'h0;
			msg_lost_irq_enable    <= 1'b0;
			count   <= 6'h00;
			wr_ptr  <= 6'h00;
			rd_ptr  <= 6'h00;
			empty   <= 1'b1;
			full    <= 1'b0;
			lost    <= 1'b0;
			rxif    <= 1'b0;
			ack     <= 1'b0;
			rdata   <= 32'h0000_0000;
			rx_irq  <= 1'b0;
			err_irq <= 1'b0;
			tx_irq  <= 1'b0;
			pend    <= 4'h0;
			rem     <= 4'h0;
			tie     <= 4'h0;
			linkm   <= 4'h0;
			cmpl    <= 4'h0;
			abrt    <= 4'h0;
			res     <= 8'h00;
			tx_req  <= 4'h0;
		end else begin
			cfg     <= next_cfg;
			gcfg    <= next_gcfg;
			msg_lost_irq_enable    <= next_msg_lost_irq_enable;
			count   <= next_count;
			wr_ptr  <= next_wr_ptr;
			rd_ptr  <= next_rd_ptr;
			empty   <= next_empty;
			full    <= next_full;
			lost    <= next_lost;
			rxif    <= next_rxif;
			ack     <= next_ack;
			rdata   <= next_rdata;
			rx_irq  <= next_rx_irq;
			err_irq <= next_err_irq;
			tx_irq  <= next_tx_irq;
			pend    <= next_pend;
			rem     <= next_rem;
			tie     <= next_tie;
			linkm   <= next_linkm;
			cmpl    <= next_cmpl;
			abrt    <= next_abrt;
			res     <= next_res;
			tx_req  <= next_tx_req;
		end
	end

	assign link.reg_ack   = ack;
	assign link.reg_rdata = rdata;
	assign tx_req_o       = tx_req;
	assign tx_remote_o    = rem;
	assign rx_irq_o       = rx_irq;
	assign err_irq_o      = err_irq;
	assign tx_irq_o       = tx_irq;

endmodule : can_fifo_dev
`default_nettype wire

// File: core/can_fifo_pkg.sv
// Purpose: Shared constants and types for the channel message FIFO (receive mode).
// Assumes: Registers are 32-bit words; the word index is the byte address divided by four.
// Notes:   Depth codes 5 and above map to the largest depth.
package can_fifo_pkg;

	localparam int ID_W      = 29;
	localparam int STD_ID_W  = 11;
	localparam int DLC_W     = 4;
	localparam int LABEL_W   = 12;
	localparam int STAMP_W   = 16;
	localparam int DATA_W    = 64;
	localparam int CNT_W     = 6;
	localparam int REG_AW    = 4;
	localparam int NUM_TXB   = 4;
	localparam int TXB_IDX_W = 2;

	localparam logic [REG_AW-1:0] REG_CONFIG  = 4'h0;
	localparam logic [REG_AW-1:0] REG_STATUS  = 4'h1;
	localparam logic [REG_AW-1:0] REG_PTRCTL  = 4'h2;
	localparam logic [REG_AW-1:0] REG_ID_LOW  = 4'h3;
	localparam logic [REG_AW-1:0] REG_ID_HIGH = 4'h4;
	localparam logic [REG_AW-1:0] REG_STAMP   = 4'h5;
	localparam logic [REG_AW-1:0] REG_LBL_DLC = 4'h6;
	localparam logic [REG_AW-1:0] REG_DATA0   = 4'h7;
	localparam logic [REG_AW-1:0] REG_DATA1   = 4'h8;
	localparam logic [REG_AW-1:0] REG_GCFG    = 4'h9;
	localparam logic [REG_AW-1:0] REG_GLOBAL_CONTROL_REG   = 4'hA;
	localparam logic [REG_AW-1:0] REG_TXCTL   = 4'hB;
	localparam logic [REG_AW-1:0] REG_TXIE    = 4'hC;
	localparam logic [REG_AW-1:0] REG_TXSTAT  = 4'hD;

	// Field positions
	localparam int CFG_EN     = 0;
	localparam int CFG_RXIE   = 1;
	localparam int CFG_TXMODE = 2;
	localparam int CFG_IRQM   = 3;
	localparam int CFG_DEPTH  = 8;
	localparam int CFG_THR    = 13;
	localparam int STS_EMPTY  = 0;
	localparam int STS_FULL   = 1;
	localparam int STS_LOST   = 2;
	localparam int STS_RXIF   = 3;
	localparam int STS_COUNT  = 8;
	localparam int GCFG_DCE   = 0;
	localparam int GCFG_DRE   = 1;
	localparam int GLOBAL_CONTROL_REG_MSG_LOST_IRQ_ENABLE = 0;
	localparam int LD_DLC     = 12;
	localparam int LD_LABEL   = 20;
	localparam int IDH_IDE    = 15;
	localparam int TX_LINK    = 8;
	localparam int TX_CMPL    = 8;
	localparam int TX_ABRT    = 16;
	localparam int TX_RES     = 24;

	localparam logic [31:0]      CONFIG_RST  = 32'h0000_0000;
	localparam logic [7:0]       PTR_ADVANCE = 8'hFF;
	localparam logic [2:0]       THR_FULL    = 3'h7;
	localparam logic [1:0]       RES_DONE    = 2'h2;
	localparam logic [1:0]       RES_ABORT   = 2'h1;

	typedef struct packed {
		logic               ide;
		logic [ID_W-1:0]    id;
		logic [STAMP_W-1:0] stamp;
		logic [LABEL_W-1:0] label;
		logic [DLC_W-1:0]   dlc;
		logic [DATA_W-1:0]  data;
	} msg_t;

	// Depth code to number of messages
	function automatic logic [CNT_W-1:0] depth_of(input logic [2:0] code);
		unique case (code)
			3'h0:    return 6'h00;
			3'h1:    return 6'h04;
			3'h2:    return 6'h08;
			3'h3:    return 6'h10;
			3'h4:    return 6'h20;
			default: return 6'h30;
		endcase
	endfunction : depth_of

	// Fill level at which the threshold interrupt fires
	function automatic logic [CNT_W-1:0] threshold_of(input logic [CNT_W-1:0] depth,
			input logic [2:0] code);
		logic [8:0] prod;
		prod = 9'(depth) * (9'(code) + 9'h001);
		return (code == THR_FULL) ? depth : prod[8:3];
	endfunction : threshold_of

endpackage : can_fifo_pkg

// File: core/can_fifo_if.sv
// Purpose: Link between the channel receive path/controller and the message FIFO.
// Assumes: Both ends share one clock; every signal is driven from a flip-flop.
// Notes:   rx_valid and reg_req are one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
interface can_fifo_if;
	import can_fifo_pkg::*;

	logic                 rx_valid;
	logic [ID_W-1:0]      rx_id;
	logic                 rx_ide;
	logic [DLC_W-1:0]     rx_dlc;
	logic [DATA_W-1:0]    rx_data;
	logic [STAMP_W-1:0]   rx_stamp;
	logic [DLC_W-1:0]     rule_dlc;
	logic [LABEL_W-1:0]   rule_label;
	logic                 reg_req;
	logic                 reg_we;
	logic [REG_AW-1:0]    reg_addr;
	logic [31:0]          reg_wdata;
	logic                 reg_ack;
	logic [31:0]          reg_rdata;

	modport device (
		input  rx_valid, rx_id, rx_ide, rx_dlc, rx_data, rx_stamp, rule_dlc, rule_label,
		input  reg_req, reg_we, reg_addr, reg_wdata,
		output reg_ack, reg_rdata
	);

	modport ctrl (
		output rx_valid, rx_id, rx_ide, rx_dlc, rx_data, rx_stamp, rule_dlc, rule_label,
		output reg_req, reg_we, reg_addr, reg_wdata,
		input  reg_ack, reg_rdata
	);

endinterface : can_fifo_if
`default_nettype wire

// File: core/msg_store.sv
// Purpose: Message storage array with one write port and one asynchronous read port.
// Assumes: Address stays below DEPTH.
// Notes:   Contents are not reset.
`timescale 1ns/10ps
`default_nettype none
module msg_store #(
	parameter int WIDTH = 126,
	parameter int DEPTH = 48,
	parameter int AW    = 6
) (
	input  wire logic             clk_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic [AW-1:0]    rd_addr_i,
	output logic      [WIDTH-1:0] rd_data_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	assign rd_data_o = mem[rd_addr_i];

endmodule : msg_store
`default_nettype wire

// File: core/can_fifo_ctrl.sv
// Purpose: Wishbone slave and receive-path feed for the channel message FIFO.
// Assumes: Filtered messages arrive as one-cycle strobes on the same clock.
// Notes:   Writes apply only with all four byte selects set.
`timescale 1ns/10ps
`default_nettype none
module can_fifo_ctrl (
	input  wire logic                               clk_i,
	input  wire logic                               rst_i,
	can_fifo_if.ctrl                                link,
	input  wire logic                               cyc_i,
	input  wire logic                               stb_i,
	input  wire logic                               we_i,
	input  wire logic [5:0]                         adr_i,
	input  wire logic [3:0]                         sel_i,
	input  wire logic [31:0]                        dat_i,
	output logic      [31:0]                        dat_o,
	output logic                                    ack_o,
	input  wire logic                               msg_valid_i,
	input  wire logic [can_fifo_pkg::ID_W-1:0]      msg_id_i,
	input  wire logic                               msg_ide_i,
	input  wire logic [can_fifo_pkg::DLC_W-1:0]     msg_dlc_i,
	input  wire logic [can_fifo_pkg::DATA_W-1:0]    msg_data_i,
	input  wire logic [can_fifo_pkg::STAMP_W-1:0]   msg_stamp_i,
	input  wire logic [can_fifo_pkg::DLC_W-1:0]     hit_dlc_i,
	input  wire logic [can_fifo_pkg::LABEL_W-1:0]   hit_label_i
);
	import can_fifo_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} bus_state_t;

	bus_state_t        state, next_state;
	logic              req, next_req;
	logic              we, next_we;
	logic [REG_AW-1:0] addr, next_addr;
	logic [31:0]       wdata, next_wdata;
	logic [31:0]       dat, next_dat;
	logic              ack, next_ack;
	msg_t              msg;
	logic              msg_valid;

	////////////////////////////////////////////////////////////////////////////////
	// Bus transaction sequencing
	always_comb begin
		next_state = state;
		next_req   = 1'b0;
		next_we    = we;
		next_addr  = addr;
		next_wdata = wdata;
		next_dat   = dat;
		next_ack   = 1'b0;
		unique case (state)
			ST_IDLE: begin
				if (cyc_i && stb_i) begin
					next_req   = 1'b1;
					next_we    = we_i && (sel_i == 4'hF);
					next_addr  = adr_i[5:2];
					next_wdata = dat_i;
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (link.reg_ack) begin
					next_dat   = link.reg_rdata;
					next_ack   = 1'b1;
					next_state = ST_DONE;
				end
			end
			ST_DONE: next_state = ST_IDLE;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= ST_IDLE;
			req       <= 1'b0;
			we        <= 1'b0;
			addr      <= 4'h0;
			wdata     <= 32'h0000_0000;
			dat       <= 32'h0000_0000;
			ack       <= 1'b0;
			msg_valid <= 1'b0;
			msg       <= '0;
		end else begin
			state     <= next_state;
			req       <= next_req;
			we        <= next_we;
			addr      <= next_addr;
			wdata     <= next_wdata;
			dat       <= next_dat;
			ack       <= next_ack;
			msg_valid <= msg_valid_i;
			msg       <= '{ide: msg_ide_i, id: msg_id_i, stamp: msg_stamp_i,
				label: hit_label_i, dlc: msg_dlc_i, data: msg_data_i};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Link outputs
	// Rule length travels apart from the received length
	logic [DLC_W-1:0] rule_dlc_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rule_dlc_q <= 4'h0;
		end else begin
			rule_dlc_q <= hit_dlc_i;
		end
	end

	assign link.reg_req    = req;
	assign link.reg_we     = we;
	assign link.reg_addr   = addr;
	assign link.reg_wdata  = wdata;
	assign link.rx_valid   = msg_valid;
	assign link.rx_id      = msg.id;
	assign link.rx_ide     = msg.ide;
	assign link.rx_dlc     = msg.dlc;
	assign link.rx_data    = msg.data;
	assign link.rx_stamp   = msg.stamp;
	assign link.rule_dlc   = rule_dlc_q;
	assign link.rule_label = msg.label;
	assign dat_o           = dat;
	assign ack_o           = ack;

endmodule : can_fifo_ctrl
`default_nettype wire

// File: sim/can_fifo_assertions.sv
// Purpose: Checks on the link between FIFO controller and device.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Read address is captured with each request.
`timescale 1ns/10ps
`default_nettype none
module can_fifo_assertions import can_fifo_pkg::*; (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              reg_req,
	input wire logic              reg_we,
	input wire logic [REG_AW-1:0] reg_addr,
	input wire logic              reg_ack,
	input wire logic [31:0]       reg_rdata
);
	logic [REG_AW-1:0] ra;
	logic [REG_AW-1:0] next_ra;
	logic              rd;
	logic              next_rd;
	always_comb begin
		next_ra = reg_req ? reg_addr : ra;
		next_rd = reg_req ? !reg_we : rd;
	end
	always_ff @(posedge clk_i) begin
		ra <= next_ra;
		rd <= next_rd;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_rd(a);
		reg_ack && rd && ra == a;
	endsequence
	property p_ack; reg_req |=> reg_ack; endproperty
	a_ack: assert property (p_ack) else $error("no answer");
	property p_ack_once; reg_ack |=> !reg_ack; endproperty
	a_ack_once: assert property (p_ack_once) else $error("long answer");
	property p_req_once; reg_req |=> !reg_req; endproperty
	a_req_once: assert property (p_req_once) else $error("long request");
	property p_empty;
		s_rd(REG_STATUS) |-> reg_rdata[STS_EMPTY] == (reg_rdata[13:8] == 6'h00);
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag wrong");
	property p_full;
		s_rd(REG_STATUS) |-> !reg_rdata[STS_FULL] || reg_rdata[13:8] inside {4, 8, 16, 32, 48};
	endproperty
	a_full: assert property (p_full) else $error("full flag wrong");
	property p_count; s_rd(REG_STATUS) |-> reg_rdata[13:8] <= 6'h30; endproperty
	a_count: assert property (p_count) else $error("count too large");
	property p_std_id;
		s_rd(REG_ID_HIGH) |-> reg_rdata[IDH_IDE] || reg_rdata[12:0] == 13'h0000;
	endproperty
	a_std_id: assert property (p_std_id) else $error("upper id bits set");
	property p_ptr; s_rd(REG_PTRCTL) |-> reg_rdata == 32'h0000_0000; endproperty
	a_ptr: assert property (p_ptr) else $error("pointer read not zero");
	property p_unmap; s_rd(4'hE) |-> reg_rdata == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule : can_fifo_assertions
`default_nettype wire

// File: sim/can_txrx_fifo_receive_mode_tb.sv
// Purpose: Self-checking bench for controller and device joined by the link.
// Assumes: Wishbone answer within 20 cycles.
// Notes:   A queue model follows the FIFO contents and flags.
`timescale 1ns/10ps
`default_nettype none
module can_txrx_fifo_receive_mode_tb;
	import can_fifo_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, mv = 0, txd = 0, txa = 0;
	logic [5:0] adr = 0;
	logic [3:0] sel = 0, hdlc = 0, txreq, txrem;
	logic [31:0] dat = 0, dat_o, q;
	logic ack_o, rx_irq, err_irq, tx_irq;
	logic [1:0] gcfg = 0, txb = 0;
	int failures = 0, num_checks = 0, seed = 32'hf6333c24;
	int en, rxie, irqm, dep, thr, rxif, lost;
	msg_t mq[$];
	msg_t m, r = '0;
	always #50 clk_i = ~clk_i;
	can_fifo_if link_if();
	can_fifo_ctrl u_can_fifo_ctrl (.clk_i(clk_i), .rst_i(rst_i), .link(link_if), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .msg_valid_i(mv), .msg_id_i(r.id), .msg_ide_i(r.ide),
		.msg_dlc_i(r.dlc), .msg_data_i(r.data), .msg_stamp_i(r.stamp), .hit_dlc_i(hdlc),
		.hit_label_i(r.label));
	can_fifo_dev u_can_fifo_dev (.clk_i(clk_i), .rst_i(rst_i), .link(link_if),
		.tx_done_i(txd), .tx_buf_i(txb), .tx_aborted_i(txa), .tx_req_o(txreq),
		.tx_remote_o(txrem), .rx_irq_o(rx_irq), .err_irq_o(err_irq), .tx_irq_o(tx_irq));
	can_fifo_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_req(link_if.reg_req),
		.reg_we(link_if.reg_we), .reg_addr(link_if.reg_addr), .reg_ack(link_if.reg_ack),
		.reg_rdata(link_if.reg_rdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 2'b00, d, 4'hF};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (ack_o === 1'b1) break;
		end
		if (n == 20) begin
			failures++;
			end_of_test;
		end
		q = dat_o;
		{cyc, stb} <= 2'b00;
	endtask : wb
	task automatic txdone(input logic [1:0] b, input logic a);
		@(posedge clk_i);
		{txd, txb, txa} <= {1'b1, b, a};
		@(posedge clk_i);
		txd <= 0;
	endtask : txdone
	function automatic logic [31:0] st;
		return {18'h0, 6'(mq.size()), 4'h0, rxif[0], lost[0], dep != 0 && mq.size() == dep,
			mq.size() == 0};
	endfunction : st
	task automatic cfg(input logic [31:0] v);
		wb(1, REG_CONFIG, v);
		{en, rxie, irqm} = {32'(v[0]), 32'(v[1]), 32'(v[3])};
		dep = v[10:8] == 0 ? 0 : v[10:8] > 4 ? 48 : 2 << v[10:8];
		thr = v[15:13] == 7 ? dep : dep * (v[15:13] + 1) / 8;
		if (!en) mq.delete();
	endtask : cfg
	task automatic push;
		logic [127:0] rnd;
		logic [3:0]   hd;
		gcfg = 2'($random(seed));
		wb(1, REG_GCFG, 32'(gcfg));
		rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
		m = rnd[125:0];
		hd = 4'($random(seed));
		@(posedge clk_i);
		{mv, r, hdlc} <= {1'b1, m, hd};
		@(posedge clk_i);
		mv <= 0;
		if (!m.ide) m.id[28:11] = 0;
		if (gcfg == 3) m.dlc = hd;
		for (int i = 0; i < 8; i++) if (i >= m.dlc) m.data[8*i+:8] = 8'h00;
		if (en && mq.size() < dep) begin
			mq.push_back(m);
			if (irqm || mq.size() == thr) rxif = 1;
		end else if (en) lost = 1;
		wb(0, REG_STATUS, 0);
		cmp(q, st());
		cmp({rx_irq, err_irq}, {rxif[0] & rxie[0], lost[0]});
	endtask : push
	task automatic pop;
		logic [31:0] e[6];
		m = mq.pop_front();
		e = '{32'(m.id[15:0]), 32'({m.ide, 2'h0, m.id[28:16]}), 32'(m.stamp),
			{m.label, 4'h0, m.dlc, 12'h0}, m.data[31:0], m.data[63:32]};
		for (int i = 0; i < 6; i++) begin
			wb(0, 4'(REG_ID_LOW + i), 0);
			cmp(q, e[i]);
		end
		wb(1, REG_PTRCTL, 32'hFF);
		wb(0, REG_STATUS, 0);
		cmp(q, st());
	endtask : pop
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{en, rxie, irqm, dep, thr, rxif, lost} = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		wb(0, REG_STATUS, 0);
		cmp(q, 32'h1);
		wb(0, 4'hE, 0);
		cmp(q, 32'h0);
		wb(0, REG_PTRCTL, 0);
		cmp(q, 32'h0);
		wb(1, REG_GLOBAL_CONTROL_REG, 1);
		cfg(32'h6103);
		repeat (5) push();
		$display("fill and overflow done");
		while (mq.size() > 0) pop();
		$display("drain done");
		wb(1, REG_PTRCTL, 32'hFF);
		wb(0, REG_STATUS, 0);
		cmp(q, st());
		cfg(0);
		wb(0, REG_STATUS, 0);
		cmp(q, st());
		wb(1, REG_STATUS, 32'hC);
		{rxif, lost} = '0;
		cfg(32'h20B);
		repeat (2) begin
			wb(1, REG_STATUS, 32'h8);
			rxif = 0;
			push();
		end
		wb(1, REG_STATUS, 32'h8);
		rxif = 0;
		cfg(32'h209);
		push();
		$display("interrupt modes done");
		wb(1, REG_TXCTL, 32'h3);
		cmp({txreq, txrem}, 8'h11);
		txdone(2'h0, 1'b0);
		wb(0, REG_TXSTAT, 0);
		cmp(q, 32'h0200_0100);
		wb(1, REG_TXIE, 32'h1);
		cmp(32'(tx_irq), 32'h1);
		cfg(32'h5);
		wb(1, REG_TXIE, 32'h200);
		wb(1, REG_TXCTL, 32'h0);
		txdone(2'h1, 1'b1);
		wb(0, REG_TXSTAT, 0);
		cmp(q, 32'h0200_0100);
		cmp(32'({tx_irq, txreq, txrem}), 32'h0);
		$display("transmit buffer done");
		end_of_test;
	end
endmodule : can_txrx_fifo_receive_mode_tb
`default_nettype wire
